// ==== design/cbu_branch_unit.sv ====
// conditional relative branch unit of the 8-bit core
`include "cbu_consts.svh"
`default_nettype none
module cbu_branch_unit (
  input  wire logic                      ref_clk_in,
  input  wire logic                      rst_in,
  input  wire cbu_pkg::cbu_req_t         req_in,
  input  wire logic [`CBU_PC_W-1:0]      pc_in,
  input  wire logic [7:0]                status_in,
  output logic                           req_ready_out,
  output logic                           done_out,
  output logic                           pc_load_out,
  output logic [`CBU_PC_W-1:0]           pc_target_out,
  output logic [7:0]                     status_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [`CBU_PC_W-1:0] rel_target(
    input logic [`CBU_PC_W-1:0]  pc,
    input logic [`CBU_OFS_W-1:0] ofs
  );
    logic [`CBU_PC_W-1:0] sx;
    sx = {{(`CBU_PC_W-`CBU_OFS_W){ofs[`CBU_OFS_W-1]}}, ofs};
    // wraps at 16 bits on purpose, the pc space is circular
    return pc + sx + `CBU_PC_W'(1);
  endfunction

  // ----------------------------------------------------------------
  // condition
  // ----------------------------------------------------------------
  logic cond_taken;
  cbu_cond_eval u_cond (
    .op_in      (req_in.op),
    .bit_sel_in (req_in.bit_sel),
    .status_in  (status_in),
    .taken_out  (cond_taken)
  );

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  cbu_pkg::cbu_state_t   state_r;
  cbu_pkg::cbu_state_t   state_nxt;
  logic                  done_r;
  logic                  done_nxt;
  logic                  load_r;
  logic                  load_nxt;
  logic [`CBU_PC_W-1:0]  tgt_r;
  logic [`CBU_PC_W-1:0]  tgt_nxt;
  logic                  accept;

  // a taken branch holds off the next request for its second cycle
  assign req_ready_out = (state_r == cbu_pkg::CBU_ST_IDLE);
  assign accept        = req_in.valid && req_ready_out;

  always_comb begin
    state_nxt = state_r;
    done_nxt  = 1'b0;
    load_nxt  = 1'b0;
    tgt_nxt   = tgt_r;
    unique case (state_r)
      cbu_pkg::CBU_ST_IDLE: begin
        if (accept && cond_taken) begin
          state_nxt = cbu_pkg::CBU_ST_TAKEN;
          tgt_nxt   = rel_target(pc_in, req_in.offset);
        end else if (accept) begin
          done_nxt = 1'b1;
        end
      end
      cbu_pkg::CBU_ST_TAKEN: begin
        state_nxt = cbu_pkg::CBU_ST_IDLE;
        done_nxt  = 1'b1;
        load_nxt  = 1'b1;
      end
      default: state_nxt = cbu_pkg::CBU_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= cbu_pkg::CBU_ST_IDLE;
      done_r  <= 1'b0;
      load_r  <= 1'b0;
      tgt_r   <= `CBU_PC_RST;
    end else begin
      state_r <= state_nxt;
      done_r  <= done_nxt;
      load_r  <= load_nxt;
      tgt_r   <= tgt_nxt;
    end
  end

  assign done_out      = done_r;
  assign pc_load_out   = load_r;
  // target stands until the next taken branch, not only with the load
  assign pc_target_out = tgt_r;
  // flags pass straight through, branches never write them
  assign status_out    = status_in;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  not_taken_one_a: assert property (
    accept && !cond_taken |=> done_out && !pc_load_out)
    else $error("not-taken branch did not finish in one cycle");
  taken_two_a: assert property (
    accept && cond_taken |=> !done_out ##1 done_out && pc_load_out)
    else $error("taken branch did not finish in two cycles");
  target_calc_a: assert property (
    accept && cond_taken |-> ##2 pc_target_out ==
      $past(pc_in, 2) + {{9{$past(req_in.offset[6], 2)}},
      $past(req_in.offset, 2)} + 16'h0001)
    else $error("branch target wrong");
  backward_a: assert property (
    accept && cond_taken && req_in.offset == 7'h7f |=>
      tgt_r == $past(pc_in))
    else $error("minus one offset did not return to pc");
  flags_kept_a: assert property (
    status_out == status_in)
    else $error("status flags altered");
  equal_done_a: assert property (
    accept && (req_in.op == cbu_pkg::CBU_OP_EQ) |=>
      done_out != $past(status_in[`CBU_FLAG_Z]))
    else $error("equal branch wrong");
  not_equal_done_a: assert property (
    accept && (req_in.op == cbu_pkg::CBU_OP_NE) |=>
      done_out == $past(status_in[`CBU_FLAG_Z]))
    else $error("not-equal branch wrong");

  // ----------------------------------------------------------------
  // checks: decisions
  // ----------------------------------------------------------------
  bit_set_a: assert property (
    req_in.op == cbu_pkg::CBU_OP_BIT_SET |->
      cond_taken == status_in[req_in.bit_sel])
    else $error("bit-set decision wrong");
  bit_clr_a: assert property (
    req_in.op == cbu_pkg::CBU_OP_BIT_CLEAR |->
      cond_taken != status_in[req_in.bit_sel])
    else $error("bit-clear decision wrong");
  carry_a: assert property (
    (req_in.op == cbu_pkg::CBU_OP_CS || req_in.op == cbu_pkg::CBU_OP_LO)
      |-> cond_taken == status_in[`CBU_FLAG_C])
    else $error("carry-set decision wrong");
  higher_a: assert property (
    (req_in.op == cbu_pkg::CBU_OP_SH || req_in.op == cbu_pkg::CBU_OP_CC)
      |-> cond_taken != status_in[`CBU_FLAG_C])
    else $error("same-or-higher decision wrong");
  minus_a: assert property (
    req_in.op == cbu_pkg::CBU_OP_MI |-> cond_taken == status_in[2])
    else $error("minus decision wrong");
  plus_decision_a: assert property (
    req_in.op == cbu_pkg::CBU_OP_PL |-> cond_taken != status_in[2])
    else $error("plus decision wrong");
  signed_ge_a: assert property (
    req_in.op == cbu_pkg::CBU_OP_GE |->
      cond_taken == !(status_in[2] ^ status_in[3]))
    else $error("signed ge decision wrong");
  signed_lt_a: assert property (
    req_in.op == cbu_pkg::CBU_OP_LT |->
      cond_taken == (status_in[2] ^ status_in[3]))
    else $error("signed lt decision wrong");

  // ----------------------------------------------------------------
  // checks: handshake and hold
  // ----------------------------------------------------------------
  // a refused request leaves no trace, so ready low lasts one cycle
  ready_gap_a: assert property (
    !req_ready_out |=> req_ready_out)
    else $error("ready held low too long");
  gap_completes_a: assert property (
    !req_ready_out |=> done_out && pc_load_out)
    else $error("taken branch did not complete after its gap");
  load_with_done_a: assert property (
    pc_load_out |-> done_out)
    else $error("pc load without done");
  done_idle_a: assert property (
    done_out |-> req_ready_out)
    else $error("not ready in a done cycle");
  no_request_quiet_a: assert property (
    !accept && req_ready_out |=> !done_out)
    else $error("done without a request");
  fall_one_cycle_a: assert property (
    done_out && !pc_load_out |-> $past(accept))
    else $error("fall-through done not one cycle after accept");
  load_after_gap_a: assert property (
    pc_load_out |-> $past(!req_ready_out))
    else $error("pc load not after the taken gap");
  target_hold_a: assert property (
    !(accept && cond_taken) |=> $stable(pc_target_out))
    else $error("target changed without a taken branch");
  state_onehot_a: assert property (
    $onehot(state_r))
    else $error("sequencer state not one-hot");

  // ----------------------------------------------------------------
  // coverage
  // ----------------------------------------------------------------
  cov_taken_c:    cover property (accept && cond_taken);
  cov_fall_c:     cover property (accept && !cond_taken);
  cov_back2back_c: cover property (accept ##1 accept);
  cov_backward_c: cover property (accept && cond_taken && req_in.offset[6]);
  cov_refused_c:  cover property (!req_ready_out && req_in.valid);

endmodule // cbu_branch_unit
`default_nettype wire

// ==== design/cbu_consts.svh ====
// constants for the conditional branch unit
`ifndef CBU_CONSTS_SVH
`define CBU_CONSTS_SVH

// status register bit positions
`define CBU_FLAG_C 3'h0
`define CBU_FLAG_Z 3'h1
`define CBU_FLAG_N 3'h2
`define CBU_FLAG_V 3'h3
// widths
`define CBU_PC_W   16
`define CBU_OFS_W  7
// reset values
`define CBU_PC_RST 16'h0000
// cycles per branch
`define CBU_CYC_NOT_TAKEN 2'h1
`define CBU_CYC_TAKEN     2'h2

`endif

// ==== design/cbu_pkg.sv ====
// types for the conditional branch unit
`default_nettype none
package cbu_pkg;

  typedef enum logic [3:0] {
    CBU_OP_BIT_SET   = 4'h0,
    CBU_OP_BIT_CLEAR = 4'h1,
    CBU_OP_EQ        = 4'h2,
    CBU_OP_NE        = 4'h3,
    CBU_OP_CS        = 4'h4,
    CBU_OP_CC        = 4'h5,
    CBU_OP_SH        = 4'h6,
    CBU_OP_LO        = 4'h7,
    CBU_OP_MI        = 4'h8,
    CBU_OP_PL        = 4'h9,
    CBU_OP_GE        = 4'ha,
    CBU_OP_LT        = 4'hb
  } cbu_op_t;

  // one decoded branch request from the decode stage
  typedef struct packed {
    logic       valid;
    cbu_op_t    op;
    logic [2:0] bit_sel;
    logic [6:0] offset;
  } cbu_req_t;

  typedef enum logic [1:0] {
    CBU_ST_IDLE  = 2'b01,
    CBU_ST_TAKEN = 2'b10
  } cbu_state_t;

endpackage : cbu_pkg
`default_nettype wire

// ==== design/cbu_cond_eval.sv ====
// branch condition evaluator
`include "cbu_consts.svh"
`default_nettype none
module cbu_cond_eval (
  input  wire logic            [3:0] op_in,
  input  wire logic            [2:0] bit_sel_in,
  input  wire logic            [7:0] status_in,
  output logic                       taken_out
);
  logic c;
  logic z;
  logic n;
  logic v;
  assign c = status_in[`CBU_FLAG_C];
  assign z = status_in[`CBU_FLAG_Z];
  assign n = status_in[`CBU_FLAG_N];
  assign v = status_in[`CBU_FLAG_V];

  always_comb begin
    unique case (cbu_pkg::cbu_op_t'(op_in))
      cbu_pkg::CBU_OP_BIT_SET:   taken_out = status_in[bit_sel_in];
      cbu_pkg::CBU_OP_BIT_CLEAR: taken_out = !status_in[bit_sel_in];
      cbu_pkg::CBU_OP_EQ:        taken_out = z;
      cbu_pkg::CBU_OP_NE:        taken_out = !z;
      cbu_pkg::CBU_OP_CS:        taken_out = c;
      cbu_pkg::CBU_OP_CC:        taken_out = !c;
      cbu_pkg::CBU_OP_SH:        taken_out = !c;
      cbu_pkg::CBU_OP_LO:        taken_out = c;
      cbu_pkg::CBU_OP_MI:        taken_out = n;
      cbu_pkg::CBU_OP_PL:        taken_out = !n;
      cbu_pkg::CBU_OP_GE:        taken_out = !(n ^ v);
      cbu_pkg::CBU_OP_LT:        taken_out = n ^ v;
      // unused opcodes never branch
      default:                   taken_out = 1'b0;
    endcase
  end
endmodule // cbu_cond_eval
`default_nettype wire

// ==== verif/cbu_pc_model.sv ====
// program counter model on the far side of the branch unit
`include "cbu_consts.svh"
`default_nettype none
module cbu_pc_model (
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 done_in,
  input  wire logic                 load_in,
  input  wire logic [`CBU_PC_W-1:0] target_in,
  output var  logic [`CBU_PC_W-1:0] pc_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // pc update
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pc_out <= `CBU_PC_RST;
    end else if (done_in && load_in) begin
      pc_out <= target_in;
    end else if (done_in) begin
      pc_out <= pc_out + 16'h0001;
    end
  end
endmodule // cbu_pc_model
`default_nettype wire

// ==== verif/tb.sv ====
// self-checking bench for the conditional branch unit
`include "cbu_consts.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk;
  logic              rst;
  cbu_pkg::cbu_req_t req;
  logic [15:0]       pc, tgt, mpc;
  logic [7:0]        st, st_o;
  logic              rdy, done, load;
  int                err_count;
  int                checks;
  cbu_branch_unit dut (.ref_clk_in(clk), .rst_in(rst), .req_in(req),
    .pc_in(pc), .status_in(st), .req_ready_out(rdy), .done_out(done),
    .pc_load_out(load), .pc_target_out(tgt), .status_out(st_o));
  cbu_pc_model pcm (.clk_in(clk), .rst_in(rst), .done_in(done),
    .load_in(load), .target_in(tgt), .pc_out(mpc));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic want(logic [3:0] op, logic [2:0] b, logic [7:0] s);
    logic c, z, n, v;
    c = s[`CBU_FLAG_C];
    z = s[`CBU_FLAG_Z];
    n = s[`CBU_FLAG_N];
    v = s[`CBU_FLAG_V];
    case (op)
      4'h0: return s[b];
      4'h1: return !s[b];
      4'h2: return z;
      4'h3: return !z;
      4'h4, 4'h7: return c;
      4'h5, 4'h6: return !c;
      4'h8: return n;
      4'h9: return !n;
      4'ha: return !(n ^ v);
      4'hb: return n ^ v;
      default: return 1'b0;
    endcase
  endfunction
  task automatic go(input logic [3:0] op, input logic [2:0] b,
                    input logic [6:0] ofs, input logic [15:0] p,
                    input logic [7:0] s);
    logic        t;
    logic [15:0] e;
    t = want(op, b, s);
    e = p + {{9{ofs[6]}}, ofs} + 16'h0001;
    @(posedge clk);
    req <= '{1'b1, cbu_pkg::cbu_op_t'(op), b, ofs};
    pc  <= p;
    st  <= s;
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    chk(st_o, s);
    chk(done, !t);
    if (t) begin
      chk(rdy, 1'b0);
      @(posedge clk);
      #1;
      chk({done, load}, 2'h3);
      chk(tgt, e);
      @(posedge clk);
      #1;
      chk(mpc, e);
    end else begin
      chk(load, 1'b0);
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic flag_ops;
    logic [7:0] sv [6];
    sv = '{8'h00, 8'h0f, 8'h04, 8'h08, 8'h0a, 8'h05};
    for (int o = 2; o < 13; o++) begin
      for (int i = 0; i < 6; i++) begin
        go(o[3:0], 3'h0, 7'h05, 16'h0100, sv[i]);
      end
    end
  endtask
  task automatic bit_ops;
    for (int o = 0; o < 2; o++) begin
      for (int b = 0; b < 8; b++) begin
        go(o[3:0], b[2:0], 7'h7f, 16'h2000, 8'ha5);
      end
    end
  endtask
  task automatic offset_edges;
    // both directions across the 16-bit wrap
    go(4'h2, 3'h0, 7'h40, 16'h0010, 8'h02);
    go(4'h2, 3'h0, 7'h3f, 16'hffff, 8'h02);
  endtask
  task automatic back_to_back;
    // fall-through branches every cycle, then one held across a taken gap
    @(posedge clk);
    req <= '{1'b1, cbu_pkg::CBU_OP_NE, 3'h0, 7'h05};
    pc  <= 16'h0300;
    st  <= 8'h02;
    @(posedge clk);
    #1;
    chk({rdy, done, load}, 3'h6);
    @(posedge clk);
    req.op     <= cbu_pkg::CBU_OP_EQ;
    req.offset <= 7'h10;
    #1;
    chk({rdy, done, load}, 3'h6);
    @(posedge clk);
    req.op <= cbu_pkg::CBU_OP_NE;
    #1;
    chk({rdy, done, load}, 3'h0);
    @(posedge clk);
    #1;
    chk({rdy, done, load}, 3'h7);
    chk(tgt, 16'h0311);
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    chk({done, load}, 2'h2);
    chk(mpc, 16'h0311);
    @(posedge clk);
    #1;
    chk(done, 1'b0);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // clock, reset, sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    req = '0;
    pc = 16'h0000;
    st = 8'h00;
    err_count = 0;
    checks = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({rdy, done, load}, 3'h4);
    chk(tgt, `CBU_PC_RST);
    flag_ops();
    bit_ops();
    offset_edges();
    back_to_back();
    report_and_stop();
  end
  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
